// file: src/brbp_pkg.sv
// shared types and constants for the bus fetch unit
package brbp_pkg;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int BRBP_AW = 20;
  localparam int BRBP_QDEPTH_WIDE = 6;
  localparam int BRBP_QDEPTH_NARROW = 4;
  localparam logic BRBP_PIN_RST = 1'b1;
  localparam logic [BRBP_AW-1:0] BRBP_RESET_FETCH_ADDR = 20'hffff0;

  // ----------------------------------------
  // bus phases and cycle kinds
  // ----------------------------------------
  typedef enum logic [2:0] {BRBP_IDLE, BRBP_T1, BRBP_T2, BRBP_T3, BRBP_TW, BRBP_T4} brbp_phase_t;
  typedef enum logic [1:0] {BRBP_FETCH, BRBP_EU_READ, BRBP_EU_WRITE} brbp_kind_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [BRBP_AW-1:0] addr;
    logic [15:0] wdata;
    logic write;
    logic io;
    logic byte_only;
    logic internal;
    logic ignore_ready;
  } brbp_eu_req_t;

  typedef struct packed {
    logic [BRBP_AW-1:0] addr;
    logic [15:0] dout;
    logic dout_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic bhe_n;
    logic io;
  } brbp_bus_t;

endpackage : brbp_pkg

// file: src/brbp_queue.sv
// prefetch queue storage, byte wide, flushable
`timescale 1ns/1ns
module brbp_queue
  import brbp_pkg::*;
#(
  parameter int DEPTH = 6
)
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic push_two_i,
  input wire logic [15:0] push_data_i,
  input wire logic pop_i,
  output logic [7:0] head_o,
  output logic head_valid_o,
  output logic [3:0] count_o
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [3:0] count;
    logic valid;
  } brbp_q_state_t;

  brbp_q_state_t s_r;
  brbp_q_state_t s_nxt;

  always_comb
  begin
    logic [3:0] c;
    c = s_r.count;
    s_nxt = s_r;
    if (flush_i)
    begin
      c = 4'h0;
    end
    else
    begin
      // pop first so a push in the same cycle lands behind the new head
      if (pop_i && c != 4'h0)
      begin
        for (int i = 0; i < DEPTH - 1; i++)
          s_nxt.mem[i] = s_r.mem[i+1];
        c = c - 4'h1;
      end
      if (push_i)
      begin
        s_nxt.mem[c[2:0]] = push_data_i[7:0];
        c = c + 4'h1;
        if (push_two_i)
        begin
          s_nxt.mem[c[2:0]] = push_data_i[15:8];
          c = c + 4'h1;
        end
      end
    end
    s_nxt.count = c;
    s_nxt.valid = (c != 4'h0);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign head_o = s_r.mem[0];
  assign head_valid_o = s_r.valid;
  assign count_o = s_r.count;

endmodule : brbp_queue

// file: src/brbp_bus_unit.sv
// bus fetch unit: bus cycles, buffer strobes, ready sync, prefetch queue
//
// Overview of operation
// - buffer enable and direction strobe are active in every bus cycle.
// - buffer enable low through the data part of each cycle, reads and writes.
// - buffer enable stays high whenever the direction strobe changes.
// - direction strobe high for writes, low for reads.
// - both strobes high during reset, then floating until the first cycle.
// - wait states while synchronized ready low, or once after not-ready at T2; no limit on their number.
// - ready ignored for on-chip registers and regions flagged to ignore it.
// - ready passes two flops; second one low forces not-ready onward.
// - not-ready seen at T2 or at T3 inserts wait states.
// - opcode fetch runs alongside execution with no visible effect.
// - wide bus queue holds six bytes; fetch when two free and no request.
// - wide bus fetches words; after odd jump one byte first, then words.
// - narrow bus queue holds four bytes; fetch one byte when one free.
// - jump flushes queue, fetches new address, feeds it on, refills from there.
// - execute unit requests stop new fetches; a fetch under way completes.
// - read strobe low from T2; input data captured at start of T4.
`timescale 1ns/1ns
module brbp_bus_unit
  import brbp_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ready_i,
  input wire logic [15:0] data_i,
  output brbp_bus_t bus_o,
  output logic buffer_enable_n_o,
  output logic buffer_enable_n_oe_o,
  output logic data_direction_o,
  output logic data_direction_oe_o,
  input wire logic eu_req_valid_i,
  input wire brbp_eu_req_t eu_req_i,
  output logic eu_ack_o,
  output logic [15:0] eu_rdata_o,
  input wire logic jump_i,
  input wire logic [BRBP_AW-1:0] jump_addr_i,
  output logic [7:0] q_byte_o,
  output logic q_valid_o,
  input wire logic q_take_i
);

  // ----------------------------------------
  // sizes per bus variant
  // ----------------------------------------
  localparam int QDEPTH = WIDE_BUS ? BRBP_QDEPTH_WIDE : BRBP_QDEPTH_NARROW;
  localparam logic [3:0] QDEPTH4 = 4'(QDEPTH);
  localparam logic [3:0] FREE_MIN = WIDE_BUS ? 4'h2 : 4'h1;

  typedef struct packed {
    brbp_phase_t phase;
    brbp_kind_t kind;
    logic single;
    logic no_ready;
    logic t2_not_ready;
    logic drop;
    logic started;
    logic [BRBP_AW-1:0] fetch_addr;
    logic [15:0] capture;
    logic rdy_s1;
    logic rdy_s2;
    brbp_bus_t bus;
    logic den_n;
    logic dtr;
    logic pin_oe;
    logic ack;
    logic [15:0] rdata;
  } brbp_state_t;

  brbp_state_t s_r;
  brbp_state_t s_nxt;
  logic q_push;
  logic q_two;
  logic [15:0] q_data;
  logic [3:0] q_count;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic ready_ok;
    logic free_ok;
    // latched low forces not-ready; falling edge sync is the board's job
    ready_ok = s_r.rdy_s2 | s_r.no_ready;
    free_ok = (QDEPTH4 - q_count) >= FREE_MIN;
    s_nxt = s_r;
    q_push = 1'b0;
    q_two = 1'b0;
    q_data = s_r.capture;
    s_nxt.ack = 1'b0;
    // first flop resolves, second is the only reader of it
    s_nxt.rdy_s1 = ready_i;
    s_nxt.rdy_s2 = s_r.rdy_s1;
    // float after the single reset clock until the first cycle
    if (!s_r.started)
      s_nxt.pin_oe = 1'b0;

    case (s_r.phase)
      BRBP_IDLE:
      begin
        if (eu_req_valid_i && !jump_i)
        begin
          // execute unit requests take the bus before opcode fetch
          s_nxt.phase = BRBP_T1;
          s_nxt.kind = eu_req_i.write ? BRBP_EU_WRITE : BRBP_EU_READ;
          s_nxt.bus.addr = eu_req_i.addr;
          s_nxt.bus.dout = eu_req_i.wdata;
          s_nxt.bus.io = eu_req_i.io;
          s_nxt.single = eu_req_i.byte_only | ~WIDE_BUS;
          s_nxt.no_ready = eu_req_i.internal | eu_req_i.ignore_ready;
        end
        else if (free_ok && !jump_i)
        begin
          s_nxt.phase = BRBP_T1;
          s_nxt.kind = BRBP_FETCH;
          s_nxt.bus.addr = s_r.fetch_addr;
          s_nxt.bus.io = 1'b0;
          s_nxt.single = ~WIDE_BUS | s_r.fetch_addr[0];
          s_nxt.no_ready = 1'b0;
        end
        if (s_nxt.phase == BRBP_T1)
        begin
          s_nxt.bus.ale = 1'b1;
          s_nxt.started = 1'b1;
          s_nxt.pin_oe = 1'b1;
          s_nxt.den_n = 1'b1;
          s_nxt.dtr = (s_nxt.kind == BRBP_EU_WRITE);
          s_nxt.bus.bhe_n = s_nxt.single & ~s_nxt.bus.addr[0];
        end
      end
      BRBP_T1:
      begin
        s_nxt.phase = BRBP_T2;
        s_nxt.bus.ale = 1'b0;
        s_nxt.den_n = 1'b0;
        s_nxt.bus.rd_n = (s_r.kind == BRBP_EU_WRITE);
        s_nxt.bus.wr_n = (s_r.kind != BRBP_EU_WRITE);
        s_nxt.bus.dout_oe = (s_r.kind == BRBP_EU_WRITE);
      end
      BRBP_T2:
      begin
        s_nxt.phase = BRBP_T3;
        s_nxt.t2_not_ready = ~ready_ok;
      end
      BRBP_T3, BRBP_TW:
      begin
        // not-ready at T2 still costs a wait even if ready returns by T3
        if (!ready_ok || (s_r.phase == BRBP_T3 && s_r.t2_not_ready))
        begin
          s_nxt.phase = BRBP_TW;
        end
        else
        begin
          s_nxt.phase = BRBP_T4;
          s_nxt.capture = data_i;
          s_nxt.bus.rd_n = 1'b1;
          s_nxt.bus.wr_n = 1'b1;
          s_nxt.den_n = 1'b1;
        end
      end
      BRBP_T4:
      begin
        s_nxt.phase = BRBP_IDLE;
        s_nxt.bus.dout_oe = 1'b0;
        s_nxt.t2_not_ready = 1'b0;
        s_nxt.drop = 1'b0;
        if (s_r.kind == BRBP_FETCH)
        begin
          // a fetch overtaken by a jump is thrown away here
          if (!s_r.drop && !jump_i)
          begin
            q_push = 1'b1;
            q_two = ~s_r.single;
            if (s_r.single && s_r.bus.addr[0] && WIDE_BUS)
              q_data = {8'h00, s_r.capture[15:8]};
            s_nxt.fetch_addr = s_r.fetch_addr + (s_r.single ? 20'h00001 : 20'h00002);
          end
        end
        else
        begin
          s_nxt.ack = 1'b1;
          s_nxt.rdata = s_r.capture;
        end
      end
      default:
      begin
        s_nxt.phase = BRBP_IDLE;
      end
    endcase

    // jump redirects the fetch pointer; the queue is flushed alongside
    if (jump_i)
    begin
      s_nxt.fetch_addr = jump_addr_i;
      if (s_r.phase != BRBP_IDLE && s_r.phase != BRBP_T4 && s_r.kind == BRBP_FETCH)
        s_nxt.drop = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r <= '0;
      s_r.phase <= BRBP_IDLE;
      s_r.kind <= BRBP_FETCH;
      s_r.fetch_addr <= BRBP_RESET_FETCH_ADDR;
      s_r.bus.rd_n <= BRBP_PIN_RST;
      s_r.bus.wr_n <= BRBP_PIN_RST;
      s_r.bus.bhe_n <= BRBP_PIN_RST;
      s_r.den_n <= BRBP_PIN_RST;
      s_r.dtr <= BRBP_PIN_RST;
      s_r.pin_oe <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // prefetch queue
  // ----------------------------------------
  brbp_queue #(
    .DEPTH(QDEPTH)
  ) u_queue (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .flush_i(jump_i),
    .push_i(q_push),
    .push_two_i(q_two),
    .push_data_i(q_data),
    .pop_i(q_take_i),
    .head_o(q_byte_o),
    .head_valid_o(q_valid_o),
    .count_o(q_count)
  );

  assign bus_o = s_r.bus;
  assign buffer_enable_n_o = s_r.den_n;
  assign buffer_enable_n_oe_o = s_r.pin_oe;
  assign data_direction_o = s_r.dtr;
  assign data_direction_oe_o = s_r.pin_oe;
  assign eu_ack_o = s_r.ack;
  assign eu_rdata_o = s_r.rdata;

endmodule : brbp_bus_unit

// file: test/brbp_bus_unit_asserts.sv
// checker for buffer strobes, ready handling and bus phases
`timescale 1ns/1ns
module brbp_bus_unit_asserts
  import brbp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ready_i,
  input wire brbp_bus_t bus_o,
  input wire logic buffer_enable_n_o,
  input wire logic buffer_enable_n_oe_o,
  input wire logic data_direction_o,
  input wire logic data_direction_oe_o,
  input wire logic eu_req_valid_i,
  input wire brbp_eu_req_t eu_req_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic ign;
  // ready does not count for these accesses
  assign ign = eu_req_valid_i && (eu_req_i.internal || eu_req_i.ignore_ready);
  AST_RST_HIGH: assert property ($rose(resetn_i) |-> buffer_enable_n_o && data_direction_o
    && buffer_enable_n_oe_o && data_direction_oe_o) else $error("strobes not high in reset");
  AST_RST_FLOAT: assert property ($rose(resetn_i) |=> !buffer_enable_n_oe_o || bus_o.ale)
    else $error("strobes still driven after reset");
  AST_ALE_OE: assert property (bus_o.ale |-> buffer_enable_n_oe_o && data_direction_oe_o
    && buffer_enable_n_o) else $error("strobes not driven in address phase");
  AST_T2_STROBE: assert property (bus_o.ale |=> (!bus_o.rd_n || !bus_o.wr_n) && !buffer_enable_n_o)
    else $error("no strobe at second phase");
  AST_DEN_RD: assert property (!bus_o.rd_n |-> !buffer_enable_n_o && !data_direction_o)
    else $error("enable or direction wrong in read");
  AST_DEN_WR: assert property (!bus_o.wr_n |-> !buffer_enable_n_o && data_direction_o)
    else $error("enable or direction wrong in write");
  AST_DIR_EDGE: assert property (data_direction_oe_o && $past(data_direction_oe_o)
    && $changed(data_direction_o) |-> buffer_enable_n_o && $past(buffer_enable_n_o))
    else $error("direction moved while enabled");
  AST_READY_GO: assert property ($fell(bus_o.rd_n) && ready_i && $past(ready_i)
    && $past(ready_i, 2) && $past(ready_i, 3) |=> !bus_o.rd_n ##1 bus_o.rd_n)
    else $error("wait inserted while ready");
  AST_WAIT_HOLD: assert property (!bus_o.rd_n && !ign && !ready_i && !$past(ready_i)
    && !$past(ready_i, 2) |=> !bus_o.rd_n) else $error("cycle ended while not ready");
  COV_WRITE: cover property (bus_o.ale ##1 !bus_o.wr_n);
  COV_WAIT: cover property (!bus_o.rd_n && !ready_i ##1 !bus_o.rd_n);
  COV_IGN: cover property (ign && !ready_i && !bus_o.rd_n);
endmodule : brbp_bus_unit_asserts

// file: test/brbp_mem_model.sv
// memory and slow device on the far side of the bus
`timescale 1ns/1ns
module brbp_mem_model
  import brbp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire brbp_bus_t bus_i,
  input wire logic stall_i,
  output logic ready_o,
  output logic [15:0] data_o
);
  logic [15:0] last_r;
  initial ready_o = 1'b1;
  initial last_r = 16'h0000;
  // clocked ready, since the unit resolves only the rising edge
  always @(posedge ref_clk_i) ready_o <= !stall_i;
  always @(posedge ref_clk_i) if (!bus_i.rd_n) last_r <= data_o;
  // byte equals its address low byte; released bus shows the inverse
  always_comb data_o = !bus_i.rd_n ? {bus_i.addr[7:0] | 8'h01, bus_i.addr[7:0] & 8'hfe} : ~last_r;
endmodule : brbp_mem_model

// file: test/brbp_bus_unit_tb.sv
// self-checking bench for the bus fetch unit
`timescale 1ns/1ns
module brbp_bus_unit_tb
  import brbp_pkg::*;
;
  logic ref_clk_i, resetn_i, ready_i, stall, eu_req_valid_i, eu_ack_o, jump_i, q_valid_o, q_take_i;
  logic buffer_enable_n_o, buffer_enable_n_oe_o, data_direction_o, data_direction_oe_o;
  logic [15:0] data_i, eu_rdata_o;
  logic [7:0] q_byte_o;
  logic [BRBP_AW-1:0] jump_addr_i;
  brbp_bus_t bus_o;
  brbp_eu_req_t eu_req_i;
  int num_errors, comparisons;
  brbp_bus_unit #(.WIDE_BUS(1'b1)) i_brbp_bus_unit (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .ready_i(ready_i), .data_i(data_i), .bus_o(bus_o), .buffer_enable_n_o(buffer_enable_n_o),
    .buffer_enable_n_oe_o(buffer_enable_n_oe_o), .data_direction_o(data_direction_o),
    .data_direction_oe_o(data_direction_oe_o), .eu_req_valid_i(eu_req_valid_i), .eu_req_i(eu_req_i),
    .eu_ack_o(eu_ack_o), .eu_rdata_o(eu_rdata_o), .jump_i(jump_i), .jump_addr_i(jump_addr_i),
    .q_byte_o(q_byte_o), .q_valid_o(q_valid_o), .q_take_i(q_take_i));
  brbp_mem_model i_brbp_mem_model (.ref_clk_i(ref_clk_i), .bus_i(bus_o), .stall_i(stall),
    .ready_o(ready_i), .data_o(data_i));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic count_ale(input int cyc, input int exp, input string what);
    int n;
    n = 0;
    repeat (cyc)
    begin
      @(negedge ref_clk_i);
      if (bus_o.ale === 1'b1) n++;
    end
    check(what, exp[19:0], n[19:0]);
  endtask : count_ale
  task automatic pop_bytes(input logic [7:0] first, input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      @(negedge ref_clk_i);
      check("queue valid", 20'h1, {19'h0, q_valid_o});
      check("queue byte", {12'h0, first + i[7:0]}, {12'h0, q_byte_o});
      q_take_i = 1'b1;
      @(negedge ref_clk_i);
      q_take_i = 1'b0;
    end
  endtask : pop_bytes
  task automatic jump_to(input logic [19:0] a);
    @(negedge ref_clk_i);
    jump_i = 1'b1;
    jump_addr_i = a;
    @(negedge ref_clk_i);
    jump_i = 1'b0;
  endtask : jump_to
  // latency counted in cycles from driving the request to the ack
  task automatic eu_op(input logic [19:0] a, input logic wr, inf, ign, st, input int lo, hi);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    // io rides on internal and byte-only on ignore-ready, so both codes get driven
    eu_req_i = '{a, 16'h5aa5, wr, inf, ign, inf, ign};
    eu_req_valid_i = 1'b1;
    stall = st;
    while (eu_ack_o !== 1'b1 && n < 60)
    begin
      @(negedge ref_clk_i);
      n++;
      if (n == 8) stall = 1'b0;
      if (bus_o.ale === 1'b1)
      begin
        check("eu addr", a, bus_o.addr);
        check("eu io", {19'h0, inf}, {19'h0, bus_o.io});
        check("eu bhe_n", {19'h0, ign & ~a[0]}, {19'h0, bus_o.bhe_n});
      end
      if (bus_o.rd_n === 1'b0 || bus_o.wr_n === 1'b0)
        check("data drive", {19'h0, wr}, {19'h0, bus_o.dout_oe});
      if (bus_o.wr_n === 1'b0)
        check("write data", {4'h0, 16'h5aa5}, {4'h0, bus_o.dout});
    end
    eu_req_valid_i = 1'b0;
    stall = 1'b0;
    check("eu latency in range", 20'h1, {19'h0, n >= lo && n <= hi});
    if (!wr && !inf) check("eu rdata", {4'h0, a[7:0] | 8'h01, a[7:0] & 8'hfe}, {4'h0, eu_rdata_o});
    if (n >= 60)
    begin
      num_errors++;
      $display("[ERR] eu ack expected 1 seen 0");
      results();
    end
  endtask : eu_op
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    resetn_i = 1'b0;
    stall = 1'b0;
    eu_req_valid_i = 1'b0;
    eu_req_i = '0;
    jump_i = 1'b0;
    jump_addr_i = '0;
    q_take_i = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (12) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    count_ale(40, 3, "fetches to fill");
    count_ale(20, 0, "fetches when full");
    pop_bytes(8'hf0, 4);
    jump_to(20'h00123);
    count_ale(40, 3, "fetches after odd jump");
    pop_bytes(8'h23, 5);
    repeat (40) @(negedge ref_clk_i);
    eu_op(20'h00400, 1'b1, 1'b0, 1'b0, 1'b0, 5, 5);
    eu_op(20'h00402, 1'b0, 1'b0, 1'b0, 1'b0, 5, 5);
    eu_op(20'h00404, 1'b0, 1'b0, 1'b0, 1'b1, 9, 20);
    eu_op(20'h00406, 1'b0, 1'b1, 1'b0, 1'b1, 5, 5);
    eu_op(20'h00408, 1'b0, 1'b0, 1'b1, 1'b1, 5, 5);
    // two pops free a word, so a fetch starts just before the request arrives
    pop_bytes(8'h28, 2);
    eu_op(20'h0040a, 1'b0, 1'b0, 1'b0, 1'b0, 9, 9);
    results();
  end
endmodule : brbp_bus_unit_tb
bind brbp_bus_unit brbp_bus_unit_asserts i_brbp_bus_unit_asserts (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .ready_i(ready_i), .bus_o(bus_o), .buffer_enable_n_o(buffer_enable_n_o),
  .buffer_enable_n_oe_o(buffer_enable_n_oe_o), .data_direction_o(data_direction_o),
  .data_direction_oe_o(data_direction_oe_o), .eu_req_valid_i(eu_req_valid_i), .eu_req_i(eu_req_i));
